// >>> inc/io_api_pkg.sv
/*
  Shared constants for the I/O register command interpreter: operation codes,
  error codes, frame sizes and the size of the local register map.
  Assumes nothing of its surroundings.
*/
package io_api_pkg;
  // ---------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_READ_BOOL  = 8'h01;
  localparam logic [7:0] OP_READ_RW    = 8'h03;
  localparam logic [7:0] OP_READ_RO    = 8'h04;
  localparam logic [7:0] OP_WRITE_BOOL = 8'h0F;
  localparam logic [7:0] OP_WRITE_RW   = 8'h10;
  localparam logic [7:0] ERR_FLAG      = 8'h80;
  // ---------------------------------------------------------------
  // Error codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ERR_FUNCTION  = 8'h01;
  localparam logic [7:0] ERR_ADDRESS   = 8'h02;
  localparam logic [7:0] ERR_VALUE     = 8'h03;
  localparam logic [7:0] ERR_FAILURE   = 8'h04;
  // ---------------------------------------------------------------
  // Local register map
  // ---------------------------------------------------------------
  localparam int         NUM_REGS      = 16;
  localparam int         NUM_BOOLS     = 16;
  localparam int         NUM_RO        = 16;
  localparam logic [15:0] MAX_COUNT    = 16'h0010;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam logic [15:0] RO_BASE      = 16'hA000;
  localparam logic [7:0]  RESP_MAX     = 8'h20;
  localparam int         BUF_DEPTH     = 2;
  localparam int         BUF_WIDTH     = 8;
  localparam logic [2:0]  HDR_LEN      = 3'h5;
endpackage

// >>> design/byte_skid_buffer.sv
/*
  Two-entry byte buffer with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
module byte_skid_buffer (
  input  wire logic                               sys_clk_i,
  input  wire logic                               sys_rst_i,
  input  wire logic [io_api_pkg::BUF_WIDTH-1:0]   in_data_i,
  input  wire logic                               in_valid_i,
  output logic                                    in_ready_o,
  output logic [io_api_pkg::BUF_WIDTH-1:0]        out_data_o,
  output logic                                    out_valid_o,
  input  wire logic                               out_ready_i
);
  import io_api_pkg::*;

  logic [BUF_WIDTH-1:0] mem [BUF_DEPTH];
  logic [BUF_WIDTH-1:0] next_mem [BUF_DEPTH];
  logic                 wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0]           fill, next_fill;
  logic                 push, pop;
  logic                 has_room, has_data, next_has_room, next_has_data;
  logic [BUF_WIDTH-1:0] head, next_head;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    push        = in_valid_i && (fill != 2'h2);
    pop         = out_ready_i && (fill != 2'h0);
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    if (push) begin
      next_mem[wr_ptr] = in_data_i;
      next_wr_ptr      = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_fill = fill + 2'h1;
    end else if (pop && !push) begin
      next_fill = fill - 2'h1;
    end
    // Outputs are registered copies of the next fill level and head entry
    next_has_room = (next_fill != 2'h2);
    next_has_data = (next_fill != 2'h0);
    next_head     = next_mem[next_rd_ptr];
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'h0;
      has_room <= 1'b1;
      has_data <= 1'b0;
      head     <= 8'h00;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
      has_room <= next_has_room;
      has_data <= next_has_data;
      head     <= next_head;
    end
  end

  assign in_ready_o  = has_room;
  assign out_valid_o = has_data;
  assign out_data_o  = head;
endmodule

// >>> design/io_api_interpreter.sv
/*
  Command interpreter giving byte-stream access to a small local register map.
  Takes one request frame, executes it, answers with one response frame.
  Assumes a byte source with valid/ready on the request side and a byte sink
  with valid/ready on the response side, all on sys_clk_i.
*/
// Notes on behaviour
// [R01] One request in, exactly one response out, then the next request. Here the next header can be taken before the buffer has drained.
// [R02] Host delivers a whole request in one transfer, never split.
// [R03] First byte is operation: 01, 03, 04 reads; 0F, 10 writes.
// [R04] Next two bytes give the first register number.
// [R05] Next two bytes give the count of consecutive registers.
// [R06] Write data follows the count, most significant byte first.
// [R07] Paired registers are only accessed together as a unit.
// [R08] First response byte echoes the operation, bit 7 set on failure.
// [R09] Second response byte is data length, or error code on failure.
// [R10] Multi-byte register values are returned most significant byte first.
// [R11] Boolean results pack first value in bit 0, eight per byte.
// [R12] Error 01 for an operation the device does not permit.
// [R13] Error 02 for a register address out of range.
// [R14] Error 03 for an unacceptable value in the request.
// [R15] Error 04 for an unrecoverable failure during execution.
// [R16] Request end is found from operation and count; payload gathered first. A count above MAX_COUNT skips the payload here.
`timescale 1ns/10ps
module io_api_interpreter (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  req_data_i,
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  output logic [7:0]       resp_data_o,
  output logic             resp_valid_o,
  input  wire logic        resp_ready_i,
  input  wire logic [15:0] ro_value_i [io_api_pkg::NUM_RO],
  input  wire logic        exec_fault_i,
  output logic [15:0]      rw_regs_o [io_api_pkg::NUM_REGS],
  output logic [15:0]      bool_regs_o
);
  import io_api_pkg::*;

  // Phases of one request: header, payload, execute, answer
  typedef enum logic [2:0] {
    ST_HDR   = 3'b000,
    ST_DATA  = 3'b001,
    ST_DRAIN = 3'b010,
    ST_EXEC  = 3'b011,
    ST_RESP  = 3'b100
  } state_t;

  state_t      state, next_state;
  logic [2:0]  hdr_cnt, next_hdr_cnt;
  logic [7:0]  opcode, next_opcode;
  logic [15:0] start, next_start;
  logic [15:0] count, next_count;
  logic [5:0]  pay_cnt, next_pay_cnt;
  logic [5:0]  pay_len;
  logic [5:0]  next_pay_len;
  logic [7:0]  payload [RESP_MAX];
  logic [7:0]  next_payload [RESP_MAX];
  logic [7:0]  err, next_err;
  logic [5:0]  out_idx, next_out_idx;
  logic [15:0] rw_regs [NUM_REGS];
  logic [15:0] next_rw_regs [NUM_REGS];
  logic [15:0] bools, next_bools;
  logic [7:0]  resp_len;
  logic [7:0]  out_byte;
  logic        is_write, is_bool, op_ok;
  logic        next_req_ready;
  logic [16:0] end_reg;
  logic [15:0] rel_start;
  logic [15:0] sel_val;
  logic [3:0]  ridx;
  logic [4:0]  bidx;

  // Buffer between the interpreter and the response sink
  // Two entries let the sink stall without losing a byte
  logic        buf_valid, buf_ready;

  byte_skid_buffer u_resp_buf (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (out_byte),
    .in_valid_i  (buf_valid),
    .in_ready_o  (buf_ready),
    .out_data_o  (resp_data_o),
    .out_valid_o (resp_valid_o),
    .out_ready_i (resp_ready_i)
  );

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  always_comb begin
    // [R03] Operation decode
    is_write = (opcode == OP_WRITE_BOOL) || (opcode == OP_WRITE_RW);
    is_bool  = (opcode == OP_READ_BOOL) || (opcode == OP_WRITE_BOOL);
    op_ok    = (opcode == OP_READ_BOOL) || (opcode == OP_READ_RW) ||
               (opcode == OP_READ_RO) || is_write;
    // Read-only words sit above their own base; the other maps start at zero
    rel_start = (opcode == OP_READ_RO) ? (start - RO_BASE) : start;
    // A start below the base wraps high and so fails the range check
    end_reg  = {1'b0, rel_start} + {1'b0, count};
    // [R16] Payload length from operation and count
    if (opcode == OP_WRITE_BOOL) begin
      pay_len = 6'((count + 16'h0007) >> 3);
    end else if (opcode == OP_WRITE_RW) begin
      pay_len = 6'(count << 1);
    end else begin
      pay_len = 6'h00;
    end
    // [R10] Response length: two bytes per word, [R11] eight bools per byte
    if (is_bool) begin
      resp_len = 8'((count + 16'h0007) >> 3);
    end else begin
      resp_len = 8'(count << 1);
    end
    if (is_write) begin
      resp_len = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Request ready
  // ---------------------------------------------------------------
  // Worked out from the next-state values so that the pin leaves a flop;
  // the cost is a second copy of the payload length decode.
  always_comb begin
    if (next_opcode == OP_WRITE_BOOL) begin
      next_pay_len = 6'((next_count + 16'h0007) >> 3);
    end else if (next_opcode == OP_WRITE_RW) begin
      next_pay_len = 6'(next_count << 1);
    end else begin
      next_pay_len = 6'h00;
    end
    case (next_state)
      ST_HDR:  next_req_ready = 1'b1;
      ST_DATA: next_req_ready = (next_pay_cnt != next_pay_len) && (next_count <= MAX_COUNT);
      default: next_req_ready = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer and register file
  // ---------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_hdr_cnt = hdr_cnt;
    next_opcode  = opcode;
    next_start   = start;
    next_count   = count;
    next_pay_cnt = pay_cnt;
    next_payload = payload;
    next_err     = err;
    next_out_idx = out_idx;
    next_rw_regs = rw_regs;
    next_bools   = bools;
    buf_valid    = 1'b0;
    out_byte     = 8'h00;
    sel_val      = 16'h0000;
    ridx         = 4'h0;
    bidx         = 5'h00;
    case (state)
      ST_HDR: begin
        // Ready is a flop, so a byte counts only when both are high
        if (req_valid_i && req_ready_o) begin
          next_hdr_cnt = hdr_cnt + 3'h1;
          case (hdr_cnt)
            3'h0: next_opcode = req_data_i;
            // [R04] Start register, high byte first
            3'h1: next_start[15:8] = req_data_i;
            3'h2: next_start[7:0] = req_data_i;
            // [R05] Register count, high byte first
            3'h3: next_count[15:8] = req_data_i;
            default: next_count[7:0] = req_data_i;
          endcase
          if (hdr_cnt == HDR_LEN - 3'h1) begin
            next_hdr_cnt = 3'h0;
            next_pay_cnt = 6'h00;
            next_state   = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        // [R06] Gather write payload straight after the count
        // An oversize count skips the payload so the error answer comes at once
        if (pay_cnt == pay_len || (count > MAX_COUNT)) begin
          next_state = ST_EXEC;
        end else begin
          // Payload bytes are taken only while the ready flop is up
          if (req_valid_i && req_ready_o) begin
            next_payload[pay_cnt[4:0]] = req_data_i;
            next_pay_cnt               = pay_cnt + 6'h01;
          end
        end
      end
      ST_EXEC: begin
        next_err     = 8'h00;
        next_out_idx = 6'h00;
        next_state   = ST_RESP;
        // Fixed check order, so each failing request gets exactly one code
        if (!op_ok) begin
          // [R12] Unknown operation
          next_err = ERR_FUNCTION;
        end else if (count == 16'h0000 || count > MAX_COUNT) begin
          // [R14] Count value not acceptable
          next_err = ERR_VALUE;
        end else if (end_reg > 17'(is_bool ? NUM_BOOLS : NUM_REGS)) begin
          // [R13] Address range outside map
          next_err = ERR_ADDRESS;
        end else if (!is_bool && (rel_start[0] || count[0])) begin
          // [R07] Words move as aligned register pairs
          next_err = ERR_ADDRESS;
        end else if (exec_fault_i) begin
          // [R15] Execution failure
          next_err = ERR_FAILURE;
        end else if (opcode == OP_WRITE_RW) begin
          for (int i = 0; i < NUM_REGS; i++) begin
            if (16'(i) >= start && 17'(i) < end_reg) begin
              next_rw_regs[i] = {payload[5'((i - start) * 2)],
                                 payload[5'((i - start) * 2 + 1)]};
            end
          end
        end else if (opcode == OP_WRITE_BOOL) begin
          for (int i = 0; i < NUM_BOOLS; i++) begin
            if (16'(i) >= start && 17'(i) < end_reg) begin
              next_bools[i] = payload[5'((i - start) >> 3)][3'((i - start) & 7)];
            end
          end
        end
      end
      ST_RESP: begin
        // [R01] Exactly one response frame per request
        // One byte is offered per cycle; a stalled sink simply holds the index
        buf_valid = 1'b1;
        if (out_idx == 6'h00) begin
          // [R08] Echo operation, error flag on failure
          out_byte = (err != 8'h00) ? (opcode | ERR_FLAG) : opcode;
        end else if (out_idx == 6'h01) begin
          // [R09] Length or error code
          out_byte = (err != 8'h00) ? err : resp_len;
        end else if (is_bool) begin
          // [R11] First value in bit 0
          for (int b = 0; b < 8; b++) begin
            bidx = 5'(start + 16'((out_idx - 6'h02) * 8) + 16'(b));
            if (16'((out_idx - 6'h02) * 8 + b) < count) begin
              out_byte[b] = bools[4'(bidx)];
            end
          end
        end else begin
          // [R10] High byte first
          ridx    = 4'(rel_start + 16'((out_idx - 6'h02) >> 1));
          sel_val = (opcode == OP_READ_RO) ? ro_value_i[ridx] : rw_regs[ridx];
          out_byte = out_idx[0] ? sel_val[7:0] : sel_val[15:8];
        end
        if (buf_ready) begin
          next_out_idx = out_idx + 6'h01;
          if ((err != 8'h00 && out_idx == 6'h01) ||
              (err == 8'h00 && 8'(out_idx) == resp_len + 8'h01)) begin
            next_state = ST_HDR;
          end
        end
      end
      default: next_state = ST_HDR;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state   <= ST_HDR;
      hdr_cnt <= 3'h0;
      opcode  <= 8'h00;
      start   <= 16'h0000;
      count   <= 16'h0000;
      pay_cnt <= 6'h00;
      err     <= 8'h00;
      out_idx <= 6'h00;
      bools   <= 16'h0000;
      // Header phase after reset, so the first byte is welcome at once
      req_ready_o <= 1'b1;
      for (int i = 0; i < RESP_MAX; i++) begin
        payload[i] <= 8'h00;
      end
      for (int i = 0; i < NUM_REGS; i++) begin
        rw_regs[i] <= REG_RESET;
      end
    end else begin
      state   <= next_state;
      hdr_cnt <= next_hdr_cnt;
      opcode  <= next_opcode;
      start   <= next_start;
      count   <= next_count;
      pay_cnt <= next_pay_cnt;
      err     <= next_err;
      out_idx <= next_out_idx;
      bools   <= next_bools;
      req_ready_o <= next_req_ready;
      payload <= next_payload;
      rw_regs <= next_rw_regs;
    end
  end

  // Register images go out straight from their flops
  assign rw_regs_o   = rw_regs;
  assign bool_regs_o = bools;
endmodule

// >>> test/io_api_interpreter_asserts.sv
/*
  Port checker for the command interpreter, bound onto io_api_interpreter.
  Assumes one clock domain and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
module io_api_interpreter_asserts (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        req_ready_o,
  input wire logic [7:0]  resp_data_o,
  input wire logic        resp_valid_o,
  input wire logic        resp_ready_i,
  input wire logic [15:0] rw_regs_o [io_api_pkg::NUM_REGS],
  input wire logic [15:0] bool_regs_o
);
  import io_api_pkg::*;
  logic [7:0] op;
  logic [7:0] next_op;
  logic [5:0] idx;
  logic [5:0] next_idx;
  logic [5:0] len;
  logic [5:0] next_len;
  wire        acc = resp_valid_o & resp_ready_i;
  wire        hdr = resp_valid_o & (idx == 6'h01);
  // ---------------------------------------------------------------
  // Position inside the response frame
  // ---------------------------------------------------------------
  always_comb begin
    next_op  = op;
    next_idx = idx;
    next_len = len;
    if (acc && idx == 6'h00) begin
      next_op  = resp_data_o;
      next_idx = 6'h01;
    end else if (acc && idx == 6'h01) begin
      next_len = op[7] ? 6'h02 : resp_data_o[5:0] + 6'h02;
      next_idx = (op[7] || resp_data_o == 8'h00) ? 6'h00 : 6'h02;
    end else if (acc) begin
      next_idx = (idx + 6'h01 == len) ? 6'h00 : idx + 6'h01;
    end
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op  <= 8'h00;
      idx <= 6'h00;
      len <= 6'h00;
    end else begin
      op  <= next_op;
      idx <= next_idx;
      len <= next_len;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  resp_hold_a:
    assert property (resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable(resp_data_o))
    else $error("response byte changed while stalled");
  err_code_a:
    assert property (hdr && op[7] |-> resp_data_o inside {[8'h01:8'h04]})
    else $error("error code out of range");
  word_len_a:
    assert property (hdr && !op[7] && (op == OP_READ_RW || op == OP_READ_RO)
      |-> resp_data_o[1:0] == 2'h0 && resp_data_o != 8'h00 && resp_data_o <= RESP_MAX)
    else $error("word read length wrong");
  write_len_a:
    assert property (hdr && (op == OP_WRITE_BOOL || op == OP_WRITE_RW) |-> resp_data_o == 8'h00)
    else $error("write reply carries data");
  bool_len_a:
    assert property (hdr && op == OP_READ_BOOL |-> resp_data_o inside {8'h01, 8'h02})
    else $error("boolean read length wrong");
  rst_idle_a:
    assert property ($fell(sys_rst_i) |-> !resp_valid_o && req_ready_o)
    else $error("not idle after reset");
  busy_resp_a:
    assert property ($rose(resp_valid_o) && idx == 6'h00 |-> !req_ready_o)
    else $error("request taken while answering");
  bool_upd_a:
    assert property ($changed(bool_regs_o) |-> $past(req_ready_o) == 1'b0)
    else $error("boolean registers changed outside execution");
  word_upd_a:
    assert property ($changed(rw_regs_o[0]) |-> $past(req_ready_o) == 1'b0)
    else $error("word register changed outside execution");
endmodule
bind io_api_interpreter io_api_interpreter_asserts chk (
  .sys_clk_i    (sys_clk_i),
  .sys_rst_i    (sys_rst_i),
  .req_ready_o  (req_ready_o),
  .resp_data_o  (resp_data_o),
  .resp_valid_o (resp_valid_o),
  .resp_ready_i (resp_ready_i),
  .rw_regs_o    (rw_regs_o),
  .bool_regs_o  (bool_regs_o)
);

// >>> test/io_host_model.sv
/*
  Host model: sends queued request bytes and gathers response bytes.
  Assumes the bench fills txq only after reset and reads rxq.
*/
`timescale 1ns/10ps
module io_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       req_ready_i,
  output logic [7:0]      req_data_o,
  output logic            req_valid_o,
  input  wire logic [7:0] resp_data_i,
  input  wire logic       resp_valid_i,
  output logic            resp_ready_o,
  input  wire logic       slow_i
);
  logic [7:0] txq [$];
  logic [7:0] rxq [$];
  logic [1:0] tick = 2'h0;
  logic       rdy;
  initial begin
    req_data_o   = 8'h00;
    req_valid_o  = 1'b0;
    resp_ready_o = 1'b0;
  end
  // Ready and valid only move at rising edges, so the take that the next
  // rising edge makes is known here, half a cycle ahead, free of races
  // whole frame back to back
  // Idle data toggles so a stale byte is never mistaken for a new one
  always @(negedge sys_clk_i) begin
    rdy           = !slow_i || tick == 2'h0;
    tick         <= tick + 2'h1;
    resp_ready_o <= rdy;
    if (rdy && resp_valid_i) rxq.push_back(resp_data_i);
    req_valid_o  <= txq.size() > 0;
    req_data_o   <= (txq.size() > 0) ? txq[0] : ~req_data_o;
    if (txq.size() > 0 && req_ready_i) void'(txq.pop_front());
  end
endmodule

// >>> test/io_register_api_interpreter_test.sv
/*
  Self-checking bench for the command interpreter.
  Assumes the host model in io_host_model and a 200 MHz clock.
*/
`timescale 1ns/10ps
module io_register_api_interpreter_test;
  import io_api_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  req_data;
  logic [7:0]  resp_data;
  logic        req_valid;
  logic        req_ready;
  logic        resp_valid;
  logic        resp_ready;
  logic        exec_fault = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] ro_value [NUM_RO];
  logic [15:0] rw_regs [NUM_REGS];
  logic [15:0] bool_regs;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  initial foreach (ro_value[i]) ro_value[i] = 16'hB000 + 16'(i);
  io_api_interpreter dut (
    .sys_clk_i    (sys_clk_i),
    .sys_rst_i    (sys_rst_i),
    .req_data_i   (req_data),
    .req_valid_i  (req_valid),
    .req_ready_o  (req_ready),
    .resp_data_o  (resp_data),
    .resp_valid_o (resp_valid),
    .resp_ready_i (resp_ready),
    .ro_value_i   (ro_value),
    .exec_fault_i (exec_fault),
    .rw_regs_o    (rw_regs),
    .bool_regs_o  (bool_regs)
  );
  io_host_model host (
    .sys_clk_i    (sys_clk_i),
    .req_ready_i  (req_ready),
    .req_data_o   (req_data),
    .req_valid_o  (req_valid),
    .resp_data_i  (resp_data),
    .resp_valid_i (resp_valid),
    .resp_ready_o (resp_ready),
    .slow_i       (slow)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Waits for the whole answer, then lingers to catch surplus bytes
  task automatic xact(input logic [7:0] req [$], input logic [7:0] exp [$]);
    int n;
    n = 0;
    host.rxq.delete();
    foreach (req[i]) host.txq.push_back(req[i]);
    while (host.rxq.size() < exp.size() && n < 500) begin
      @(negedge sys_clk_i);
      n++;
    end
    repeat (12) @(negedge sys_clk_i);
    check(16'(host.rxq.size()), 16'(exp.size()));
    foreach (exp[i]) check({8'h00, host.rxq[i]}, {8'h00, exp[i]});
  endtask
  task automatic test_words;
    xact({OP_WRITE_RW, 8'h00, 8'h00, 8'h00, 8'h02, 8'h12, 8'h34, 8'h56, 8'h78},
         {OP_WRITE_RW, 8'h00});
    check(rw_regs[0], 16'h1234);
    check(rw_regs[1], 16'h5678);
    slow = 1'b1;
    xact({OP_READ_RW, 8'h00, 8'h00, 8'h00, 8'h02},
         {OP_READ_RW, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78});
    slow = 1'b0;
  endtask
  task automatic test_bools;
    xact({OP_WRITE_BOOL, 8'h00, 8'h00, 8'h00, 8'h09, 8'hA5, 8'h01},
         {OP_WRITE_BOOL, 8'h00});
    check(bool_regs, 16'h01A5);
    xact({OP_READ_BOOL, 8'h00, 8'h00, 8'h00, 8'h09}, {OP_READ_BOOL, 8'h02, 8'hA5, 8'h01});
    xact({OP_READ_BOOL, 8'h00, 8'h01, 8'h00, 8'h08}, {OP_READ_BOOL, 8'h01, 8'hD2});
  endtask
  task automatic test_ro;
    xact({OP_READ_RO, RO_BASE[15:8], RO_BASE[7:0] + 8'h02, 8'h00, 8'h02},
         {OP_READ_RO, 8'h04, 8'hB0, 8'h02, 8'hB0, 8'h03});
  endtask
  task automatic test_errors;
    logic [39:0] bad [6];
    logic [7:0]  code [6];
    logic [39:0] e;
    bad  = '{{8'h05, 32'h0000_0002}, {OP_READ_RW, 32'h0010_0002}, {OP_READ_RW, 32'h0001_0002},
             {OP_READ_RW, 32'h0000_0000}, {OP_READ_BOOL, 32'h0000_0011},
             {OP_READ_RO, RO_BASE + 16'h000E, 16'h0004}};
    code = '{ERR_FUNCTION, ERR_ADDRESS, ERR_ADDRESS, ERR_VALUE, ERR_VALUE, ERR_ADDRESS};
    foreach (bad[i]) begin
      e = bad[i];
      xact({e[39:32], e[31:24], e[23:16], e[15:8], e[7:0]},
           {e[39:32] | ERR_FLAG, code[i]});
    end
  endtask
  task automatic test_fault;
    exec_fault = 1'b1;
    xact({OP_READ_RW, 8'h00, 8'h00, 8'h00, 8'h02}, {OP_READ_RW | ERR_FLAG, ERR_FAILURE});
    exec_fault = 1'b0;
  endtask
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Ceiling is more than ten times the expected run length
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    @(negedge sys_clk_i);
    test_words();
    test_bools();
    test_ro();
    test_errors();
    test_fault();
    end_sim();
  end
endmodule
